/* common/fp_dp_regs.svh */
// Purpose: register offsets, command fields and reset values of the fp datapath
// Assumes: 8-bit byte address on the register bus, one word per register
// Notes: definitions only
`ifndef FP_DP_REGS_SVH
`define FP_DP_REGS_SVH

`define OFF_CMD      8'h00
`define OFF_CORE_A   8'h04
`define OFF_CORE_B   8'h08
`define OFF_RES_A    8'h0C
`define OFF_RES_B    8'h10
`define OFF_FP_STATUS_CONTROL_REG    8'h14
`define OFF_FLAGS    8'h18
`define OFF_SP       8'h1C
`define OFF_STATUS   8'h20
`define OFF_FPSEL    8'h24
`define OFF_FPDATA   8'h28

`define CMD_OP_LSB   0
`define CMD_DBL      5
`define CMD_HALF     6
`define CMD_FLG      7
`define CMD_D_LSB    8
`define CMD_N_LSB    16
`define CMD_M_LSB    24

`define RST_WORD     32'h0000_0000
`define RST_SP       32'h0000_0100
`define MAX_LIST     5'h10
`define NUM_SREG     7'h20

`endif

/* common/fp_dp_pkg.sv */
// Purpose: shared types of the fp move and arithmetic datapath
// Assumes: command op codes follow the order of fp_op_e from zero
// Notes: offsets and field positions are in fp_dp_regs.svh
package fp_dp_pkg;

  typedef enum logic [4:0] {
    fp_nop_op,
    fp_mul_acc_op,
    fp_mul_sub_op,
    fp_multiply_op,
    fp_negate_op,
    fp_neg_mul_acc_op,
    fp_neg_mul_sub_op,
    fp_neg_multiply_op,
    fp_move_imm_op,
    fp_move_op,
    fp_double_to_core_op,
    fp_core_to_double_op,
    fp_single_to_core_op,
    fp_core_to_single_op,
    fp_pair_to_core_op,
    fp_core_to_pair_op,
    fp_status_read_op,
    fp_status_write_op,
    fp_stack_push_op,
    fp_stack_pop_op
  } fp_op_e;

  typedef enum logic [1:0] {
    st_idle,
    st_exec,
    st_stack
  } dp_state_e;

endpackage

/* rtl/fp32_mac_unit.sv */
// Purpose: single-precision product and sum with optional sign flips
// Assumes: normal operands only; inf and nan inputs are not special-cased
// Notes: truncating, denormals flush to zero, overflow saturates to infinity
module fp32_mac_unit (
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  input  wire logic [31:0] c,
  input  wire logic        neg_p,
  input  wire logic        neg_c,
  output logic      [31:0] prod,
  output logic      [31:0] sum
);
  logic [47:0] pm;
  logic [9:0]  pe;
  logic        pz;
  logic [31:0] x;
  logic [31:0] big;
  logic [31:0] sml;
  logic [26:0] mb;
  logic [26:0] ms;
  logic [27:0] s;
  logic [27:0] n;
  logic [9:0]  e;
  logic        swap;

  assign pz = (a[30:23] == 8'h00) | (b[30:23] == 8'h00);
  assign pm = {1'b1, a[22:0]} * {1'b1, b[22:0]};
  assign pe = {2'b00, a[30:23]} + {2'b00, b[30:23]} - 10'h07F + {9'h000, pm[47]};

  // pe[9] marks a negative exponent, i.e. underflow
  always_comb begin
    if (pz | pe[9] | (pe == 10'h000)) prod = 32'h0000_0000;
    else if (pe >= 10'h0FF) prod = {1'b0, 8'hFF, 23'h00_0000};
    else prod = {1'b0, pe[7:0], pm[47] ? pm[46:24] : pm[45:23]};
    prod[31] = a[31] ^ b[31] ^ neg_p;
  end

  assign x    = {c[31] ^ neg_c, c[30:0]};
  assign swap = prod[30:0] > x[30:0];
  assign big  = swap ? prod : x;
  assign sml  = swap ? x : prod;
  assign mb   = (big[30:23] == 8'h00) ? {27{1'b0}} : {1'b1, big[22:0], 3'b000};
  assign ms   = ((sml[30:23] == 8'h00) ? {27{1'b0}} : {1'b1, sml[22:0], 3'b000})
                >> (big[30:23] - sml[30:23]);
  assign s    = (big[31] == sml[31]) ? {1'b0, mb} + {1'b0, ms} : {1'b0, mb} - {1'b0, ms};

  // one right step for carry out, else left steps until the hidden bit
  always_comb begin
    n = s;
    e = {2'b00, big[30:23]};
    if (s[27]) begin
      n = s >> 1;
      e = e + 10'h001;
    end else begin
      for (int i = 0; i < 26; i++) begin
        if (!n[26] && (e != 10'h000)) begin
          n = n << 1;
          e = e - 10'h001;
        end
      end
    end
    if ((s == 28'h000_0000) || (e == 10'h000) || !n[26]) sum = 32'h0000_0000;
    else if (e >= 10'h0FF) sum = {big[31], 8'hFF, 23'h00_0000};
    else sum = {big[31], e[7:0], n[25:3]};
  end

endmodule // fp32_mac_unit

/* rtl/fp_move_arith_datapath.sv */
`include "fp_dp_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// Purpose: fp extension datapath: arithmetic, moves, status and stack transfers
// Assumes: core writes operands and a command word over the register bus
// Notes: one command at a time; stack is a local 64-word memory
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - multiply-accumulate adds product of sources to destination, writes destination
// - multiply-subtract subtracts product from destination, writes destination
// - immediate move loads expanded single constant into selected register
// - register move copies unchanged, double or single width
// - double-to-core read: half 0 lower word, half 1 upper word
// - core-to-double write places word into half chosen by index
// - single transfers move all 32 bits either way unmodified
// - paired transfers use adjacent singles and two free core values
// - status read copies whole status word to core result
// - status read to flags target copies nzcv into core flags
// - status write replaces status word with core value
// - multiply writes product, old destination unused
// - negate flips only the sign bit into destination
// - negated accumulate writes minus product minus old destination
// - negated subtract writes product minus old destination
// - negated multiply writes negated product
// - pop loads one to sixteen consecutive registers from stack words
// - push stores one to sixteen consecutive registers to stack
module fp_move_arith_datapath (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [3:0]  core_nzcv,
  output logic             busy
);
  logic [31:0] sreg_q [0:31];
  logic [31:0] stack_q [0:63];
  logic [31:0] cmd_q;
  logic [31:0] core_a_q;
  logic [31:0] core_b_q;
  logic [31:0] res_a_q;
  logic [31:0] res_b_q;
  logic [31:0] fp_status_control_reg_q;
  logic [31:0] sp_q;
  logic [4:0]  fpsel_q;
  logic        err_q;
  logic [4:0]  start_q;
  logic [5:0]  words_q;
  logic [5:0]  base_q;
  logic [4:0]  idx_q;
  fp_dp_pkg::dp_state_e state_q;
  fp_dp_pkg::dp_state_e state_d;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire setup    = psel & ~penable;
  wire wr       = psel & penable & pready & pwrite;
  wire hit_cmd  = paddr == `OFF_CMD;
  wire hit_ca   = paddr == `OFF_CORE_A;
  wire hit_cb   = paddr == `OFF_CORE_B;
  wire hit_ra   = paddr == `OFF_RES_A;
  wire hit_rb   = paddr == `OFF_RES_B;
  wire hit_fpsc = paddr == `OFF_FP_STATUS_CONTROL_REG;
  wire hit_flg  = paddr == `OFF_FLAGS;
  wire hit_sp   = paddr == `OFF_SP;
  wire hit_st   = paddr == `OFF_STATUS;
  wire hit_sel  = paddr == `OFF_FPSEL;
  wire hit_fpd  = paddr == `OFF_FPDATA;
  wire ro_hit   = hit_ra | hit_rb | hit_fpsc | hit_flg | hit_st | hit_fpd;
  wire mapped   = ro_hit | hit_cmd | hit_ca | hit_cb | hit_sp | hit_sel;
  // a command written while busy is dropped, not queued
  wire cmd_go   = wr & hit_cmd & (state_q == fp_dp_pkg::st_idle);

  wire [31:0] rd_val = hit_cmd  ? cmd_q :
                       hit_ca   ? core_a_q :
                       hit_cb   ? core_b_q :
                       hit_ra   ? res_a_q :
                       hit_rb   ? res_b_q :
                       hit_fpsc ? fp_status_control_reg_q :
                       hit_flg  ? {28'h000_0000, core_nzcv} :
                       hit_sp   ? sp_q :
                       hit_st   ? {28'h000_0000, 2'h0, err_q, busy} :
                       hit_sel  ? {24'h00_0000, 3'h0, fpsel_q} :
                       hit_fpd  ? sreg_q[fpsel_q] : 32'h0000_0000;

  // one wait-free access cycle, data captured during setup
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `RST_WORD;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata  <= rd_val;
        pslverr <= ~mapped | (pwrite & ro_hit);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_q    <= `RST_WORD;
      core_a_q <= `RST_WORD;
      core_b_q <= `RST_WORD;
      fpsel_q  <= 5'h00;
    end else if (wr) begin
      if (cmd_go) cmd_q <= pwdata;
      if (hit_ca) core_a_q <= pwdata;
      if (hit_cb) core_b_q <= pwdata;
      if (hit_sel) fpsel_q <= pwdata[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command fields and operands
  wire fp_dp_pkg::fp_op_e f_op = fp_dp_pkg::fp_op_e'(cmd_q[`CMD_OP_LSB +: 5]);
  wire        f_dbl  = cmd_q[`CMD_DBL];
  wire        f_half = cmd_q[`CMD_HALF];
  wire        f_flg  = cmd_q[`CMD_FLG];
  wire [4:0]  f_d    = cmd_q[`CMD_D_LSB +: 5];
  wire [4:0]  f_n    = cmd_q[`CMD_N_LSB +: 5];
  wire [4:0]  f_m    = cmd_q[`CMD_M_LSB +: 5];
  wire [7:0]  f_imm  = cmd_q[`CMD_N_LSB +: 8];
  wire        exec   = state_q == fp_dp_pkg::st_exec;
  wire        in_stk = state_q == fp_dp_pkg::st_stack;
  wire        is_push = f_op == fp_dp_pkg::fp_stack_push_op;
  wire        is_stk = is_push | (f_op == fp_dp_pkg::fp_stack_pop_op);

  wire [31:0] sd_v  = sreg_q[f_d];
  wire [31:0] sn_v  = sreg_q[f_n];
  wire [31:0] sm_v  = sreg_q[f_m];
  wire [31:0] dn_lo = sreg_q[{f_m[3:0], 1'b0}];
  wire [31:0] dn_hi = sreg_q[{f_m[3:0], 1'b1}];
  wire [31:0] imm_v = {f_imm[7], ~f_imm[6], {5{f_imm[6]}}, f_imm[5:0], {19{1'b0}}};

  // list length and range check for push and pop
  wire [4:0]  start  = f_dbl ? {f_d[3:0], 1'b0} : f_d;
  wire [5:0]  words  = f_dbl ? {f_n, 1'b0} : {1'b0, f_n};
  wire [6:0]  top    = {2'b00, start} + {1'b0, words};
  wire list_ok = (f_n != 5'h00) && (f_n <= `MAX_LIST) && (top <= `NUM_SREG);
  wire pair_bad = ((f_op == fp_dp_pkg::fp_core_to_pair_op) && (f_d == 5'h1F)) ||
                  ((f_op == fp_dp_pkg::fp_pair_to_core_op) && (f_m == 5'h1F));
  wire bad     = (is_stk & ~list_ok) | pair_bad;
  wire stk_go  = exec & is_stk & list_ok;
  wire [31:0] step = {24'h00_0000, words, 2'b00};
  wire [5:0]  sp_idx = sp_q[7:2];
  wire        last = {1'b0, idx_q} == (words_q - 6'h01);

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic
  // sign flips of product and old destination
  wire neg_p = (f_op == fp_dp_pkg::fp_mul_sub_op) | (f_op == fp_dp_pkg::fp_neg_mul_acc_op) |
               (f_op == fp_dp_pkg::fp_neg_multiply_op);
  wire neg_c = (f_op == fp_dp_pkg::fp_neg_mul_acc_op) | (f_op == fp_dp_pkg::fp_neg_mul_sub_op);
  logic [31:0] mac_prod;
  logic [31:0] mac_sum;

  fp32_mac_unit u_mac (
    .a     (sn_v),
    .b     (sm_v),
    .c     (sd_v),
    .neg_p (neg_p),
    .neg_c (neg_c),
    .prod  (mac_prod),
    .sum   (mac_sum)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write ports and result selection
  logic        we0;
  logic        we1;
  logic [4:0]  wi0;
  logic [4:0]  wi1;
  logic [31:0] wd0;
  logic [31:0] wd1;
  logic [31:0] res_a_d;
  logic [31:0] res_b_d;
  logic [31:0] fp_status_control_reg_d;
  logic [3:0]  nzcv_d;

  always_comb begin
    we0 = 1'b0;
    we1 = 1'b0;
    wi0 = f_d;
    wi1 = f_d + 5'h01;
    wd0 = `RST_WORD;
    wd1 = `RST_WORD;
    res_a_d = res_a_q;
    res_b_d = res_b_q;
    fp_status_control_reg_d = fp_status_control_reg_q;
    nzcv_d  = core_nzcv;
    if (in_stk && !is_push) begin
      we0 = 1'b1;
      wi0 = start_q + idx_q;
      wd0 = stack_q[base_q + {1'b0, idx_q}];
    end else if (exec && !bad) begin
      case (f_op)
        fp_dp_pkg::fp_mul_acc_op, fp_dp_pkg::fp_mul_sub_op,
        fp_dp_pkg::fp_neg_mul_acc_op, fp_dp_pkg::fp_neg_mul_sub_op: begin
          we0 = 1'b1;
          wd0 = mac_sum;
        end
        fp_dp_pkg::fp_multiply_op, fp_dp_pkg::fp_neg_multiply_op: begin
          we0 = 1'b1;
          wd0 = mac_prod;
        end
        fp_dp_pkg::fp_negate_op: begin
          we0 = 1'b1;
          wd0 = {~sm_v[31], sm_v[30:0]};
        end
        fp_dp_pkg::fp_move_imm_op: begin
          we0 = 1'b1;
          wd0 = imm_v;
        end
        fp_dp_pkg::fp_move_op: begin
          we0 = 1'b1;
          if (f_dbl) begin
            we1 = 1'b1;
            wi0 = {f_d[3:0], 1'b0};
            wi1 = {f_d[3:0], 1'b1};
            wd0 = dn_lo;
            wd1 = dn_hi;
          end else begin
            wd0 = sm_v;
          end
        end
        fp_dp_pkg::fp_double_to_core_op: res_a_d = f_half ? dn_hi : dn_lo;
        fp_dp_pkg::fp_core_to_double_op: begin
          we0 = 1'b1;
          wi0 = {f_d[3:0], f_half};
          wd0 = core_a_q;
        end
        fp_dp_pkg::fp_single_to_core_op: res_a_d = sm_v;
        fp_dp_pkg::fp_core_to_single_op: begin
          we0 = 1'b1;
          wd0 = core_a_q;
        end
        fp_dp_pkg::fp_pair_to_core_op: begin
          res_a_d = sm_v;
          res_b_d = sreg_q[f_m + 5'h01];
        end
        fp_dp_pkg::fp_core_to_pair_op: begin
          we0 = 1'b1;
          we1 = 1'b1;
          wd0 = core_a_q;
          wd1 = core_b_q;
        end
        fp_dp_pkg::fp_status_read_op: begin
          if (f_flg) nzcv_d = fp_status_control_reg_q[31:28];
          else res_a_d = fp_status_control_reg_q;
        end
        fp_dp_pkg::fp_status_write_op: fp_status_control_reg_d = core_a_q;
        default: we0 = 1'b0;
      endcase
    end
  end

  always_comb begin
    case (state_q)
      fp_dp_pkg::st_idle:  state_d = cmd_go ? fp_dp_pkg::st_exec : fp_dp_pkg::st_idle;
      fp_dp_pkg::st_exec:  state_d = stk_go ? fp_dp_pkg::st_stack : fp_dp_pkg::st_idle;
      fp_dp_pkg::st_stack: state_d = last ? fp_dp_pkg::st_idle : fp_dp_pkg::st_stack;
      default:             state_d = fp_dp_pkg::st_idle;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and datapath registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= fp_dp_pkg::st_idle;
      busy      <= 1'b0;
      res_a_q   <= `RST_WORD;
      res_b_q   <= `RST_WORD;
      fp_status_control_reg_q   <= `RST_WORD;
      core_nzcv <= 4'h0;
      err_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      busy      <= state_d != fp_dp_pkg::st_idle;
      res_a_q   <= res_a_d;
      res_b_q   <= res_b_d;
      fp_status_control_reg_q   <= fp_status_control_reg_d;
      core_nzcv <= nzcv_d;
      if (cmd_go) err_q <= 1'b0;
      else if (exec & bad) err_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp_q    <= `RST_SP;
      start_q <= 5'h00;
      words_q <= 6'h00;
      base_q  <= 6'h00;
      idx_q   <= 5'h00;
    end else if (stk_go) begin
      // sp moves by whole list at start
      sp_q    <= is_push ? sp_q - step : sp_q + step;
      start_q <= start;
      words_q <= words;
      base_q  <= is_push ? sp_idx - words : sp_idx;
      idx_q   <= 5'h00;
    end else if (in_stk) begin
      idx_q <= idx_q + 5'h01;
    end else if (wr && hit_sp) begin
      sp_q <= pwdata;
    end
  end

  // storage arrays carry no reset, contents are software data
  always_ff @(posedge clk) begin
    if (we0) sreg_q[wi0] <= wd0;
    if (we1) sreg_q[wi1] <= wd1;
  end

  always_ff @(posedge clk) begin
    if (in_stk && is_push) stack_q[base_q + {1'b0, idx_q}] <= sreg_q[start_q + idx_q];
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  wire op_ok = exec && !bad;

  sequence s_push_go;
    stk_go && is_push;
  endsequence

  sequence s_pop_go;
    stk_go && !is_push;
  endsequence

  AST_MLA_WB: assert property (
    op_ok && f_op == fp_dp_pkg::fp_mul_acc_op |=> sreg_q[$past(f_d)] == $past(mac_sum))
    else $error("accumulate result not written");
  AST_MLS_SIGN: assert property (
    op_ok && f_op == fp_dp_pkg::fp_mul_sub_op |-> neg_p && !neg_c && we0 && wd0 == mac_sum)
    else $error("subtract form uses wrong signs");
  AST_IMM: assert property (
    op_ok && f_op == fp_dp_pkg::fp_move_imm_op |=> sreg_q[$past(f_d)] == $past(imm_v))
    else $error("immediate not loaded");
  AST_HALF_RD: assert property (
    op_ok && f_op == fp_dp_pkg::fp_double_to_core_op
    |=> res_a_q == sreg_q[{$past(f_m[3:0]), $past(f_half)}])
    else $error("wrong half read");
  AST_HALF_KEEP: assert property (
    op_ok && f_op == fp_dp_pkg::fp_core_to_double_op
    |=> sreg_q[{$past(f_d[3:0]), ~$past(f_half)}] == $past(sreg_q[{f_d[3:0], ~f_half}])
        && sreg_q[{$past(f_d[3:0]), $past(f_half)}] == $past(core_a_q))
    else $error("half write disturbed other half");
  AST_PAIR_WR: assert property (
    op_ok && f_op == fp_dp_pkg::fp_core_to_pair_op
    |=> sreg_q[$past(f_d)] == $past(core_a_q) && sreg_q[$past(f_d) + 5'h01] == $past(core_b_q))
    else $error("pair write wrong");
  AST_FLAGS: assert property (
    op_ok && f_op == fp_dp_pkg::fp_status_read_op && f_flg
    |=> core_nzcv == $past(fp_status_control_reg_q[31:28]) && $stable(res_a_q))
    else $error("flags not copied");
  AST_FP_STATUS_CONTROL_REG_WR: assert property (
    op_ok && f_op == fp_dp_pkg::fp_status_write_op |=> fp_status_control_reg_q == $past(core_a_q))
    else $error("status word not replaced");
  AST_NEG: assert property (
    op_ok && f_op == fp_dp_pkg::fp_negate_op
    |=> sreg_q[$past(f_d)] == ($past(sm_v) ^ 32'h8000_0000))
    else $error("negate changed more than sign");
  AST_POP_WORD: assert property (
    in_stk && !is_push
    |=> sreg_q[$past(start_q + idx_q)] == $past(stack_q[base_q + {1'b0, idx_q}]))
    else $error("pop word not loaded");
  AST_LIST_BAD: assert property (
    exec && is_stk && !list_ok |=> state_q == fp_dp_pkg::st_idle && err_q && $stable(sp_q))
    else $error("bad list not refused");
  AST_PUSH_SP: assert property (
    s_push_go |=> sp_q == $past(sp_q) - $past(step) && in_stk)
    else $error("push did not lower sp");
  AST_POP_SP: assert property (
    s_pop_go |=> sp_q == $past(sp_q) + $past(step) && in_stk)
    else $error("pop did not raise sp");

endmodule // fp_move_arith_datapath

/* test/core_model.sv */
////////////////////////////////////////////////////////////////////////////////
// Purpose: core side of the block, the master on its register bus
// Assumes: one transfer at a time, each begun just after a rising edge
// Notes: waits on pready without limit; the bench timeout cuts a hang
////////////////////////////////////////////////////////////////////////////////
module core_model (
  input  wire logic        clk,
  output logic      [7:0]  paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    paddr   = 8'h00;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    pwdata  = 32'h0000_0000;
  end

  // no pc or sp: core values reach the block only as data words
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'h1;
    // request held until the rising edge that sees pready high
    @(posedge clk);
    while (pready !== 1'h1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule // core_model

/* test/tb.sv */
////////////////////////////////////////////////////////////////////////////////
// Purpose: self-checking bench of the fp move and arithmetic datapath
// Assumes: float operands chosen so every result is exact
// Notes: fp registers are loaded and read back over the register bus
////////////////////////////////////////////////////////////////////////////////
`include "fp_dp_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rstn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  core_nzcv;
  logic        busy;
  logic [31:0] rdat;
  logic        perr;
  int          num_errors;
  int          tests_run;
  int          cycles;

  always #20 clk = ~clk;

  fp_move_arith_datapath dut_u (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_nzcv(core_nzcv), .busy(busy));
  core_model core_u (.clk(clk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    core_u.xfer(1'h1, a, d, rdat, perr);
  endtask

  task automatic rd(input logic [7:0] a);
    core_u.xfer(1'h0, a, 32'h0000_0000, rdat, perr);
  endtask

  // fl is {flags target, half, double}; leaves the final status word in rdat
  task automatic cmd(input logic [4:0] op, input logic [2:0] fl, input logic [4:0] d,
                     input logic [7:0] n, input logic [4:0] m);
    int i;
    wr(`OFF_CMD, {3'h0, m, n, 3'h0, d, fl, op});
    i = 0;
    rd(`OFF_STATUS);
    while (rdat[0] !== 1'h0 && i < 60) begin
      rd(`OFF_STATUS);
      i++;
    end
    chk_bit(busy, 1'h0);
  endtask

  task automatic sset(input logic [4:0] s, input logic [31:0] v);
    wr(`OFF_CORE_A, v);
    cmd(5'h0D, 3'h0, s, 8'h00, 5'h00);
  endtask

  task automatic sget(input logic [4:0] s);
    wr(`OFF_FPSEL, {27'h0, s});
    rd(`OFF_FPDATA);
  endtask

  task automatic t_bus;
    rd(`OFF_SP);
    chk_word(rdat, 32'h0000_0100);
    rd(8'h2C);
    chk_bit(perr, 1'h1);
    wr(`OFF_RES_A, 32'h0000_0001);
    chk_bit(perr, 1'h1);
  endtask

  task automatic t_arith;
    logic [31:0] ex [8] = '{32'h0, 32'h40E0_0000, 32'hC0A0_0000, 32'h40C0_0000,
                            32'h0, 32'hC0E0_0000, 32'h40A0_0000, 32'hC0C0_0000};
    sset(5'h02, 32'h4000_0000);
    sset(5'h03, 32'h4040_0000);
    for (int k = 1; k < 8; k++) begin
      if (k != 4) begin
        sset(5'h01, 32'h3F80_0000);
        cmd(5'(k), 3'h0, 5'h01, 8'h02, 5'h03);
        sget(5'h01);
        chk_word(rdat, ex[k]);
      end
    end
  endtask

  task automatic t_moves;
    cmd(5'h08, 3'h0, 5'h0A, 8'h70, 5'h00);
    sget(5'h0A);
    chk_word(rdat, 32'h3F80_0000);
    cmd(5'h04, 3'h0, 5'h04, 8'h00, 5'h03);
    sget(5'h04);
    chk_word(rdat, 32'hC040_0000);
    cmd(5'h09, 3'h0, 5'h05, 8'h00, 5'h03);
    sget(5'h05);
    chk_word(rdat, 32'h4040_0000);
    cmd(5'h09, 3'h1, 5'h03, 8'h00, 5'h01);
    sget(5'h06);
    chk_word(rdat, 32'h4000_0000);
    sget(5'h07);
    chk_word(rdat, 32'h4040_0000);
  endtask

  task automatic t_xfer;
    for (int h = 0; h < 2; h++) begin
      cmd(5'h0A, {1'h0, 1'(h), 1'h0}, 5'h00, 8'h00, 5'h01);
      rd(`OFF_RES_A);
      chk_word(rdat, (h == 1) ? 32'h4040_0000 : 32'h4000_0000);
    end
    wr(`OFF_CORE_A, 32'h1234_5678);
    cmd(5'h0B, 3'h2, 5'h02, 8'h00, 5'h00);
    sget(5'h05);
    chk_word(rdat, 32'h1234_5678);
    sget(5'h04);
    chk_word(rdat, 32'hC040_0000);
    cmd(5'h0C, 3'h0, 5'h00, 8'h00, 5'h05);
    rd(`OFF_RES_A);
    chk_word(rdat, 32'h1234_5678);
    wr(`OFF_CORE_A, 32'hDEAD_0001);
    wr(`OFF_CORE_B, 32'h0BEE_F002);
    cmd(5'h0F, 3'h0, 5'h08, 8'h00, 5'h00);
    cmd(5'h0E, 3'h0, 5'h00, 8'h00, 5'h08);
    rd(`OFF_RES_B);
    chk_word(rdat, 32'h0BEE_F002);
    sget(5'h08);
    chk_word(rdat, 32'hDEAD_0001);
    cmd(5'h0F, 3'h0, 5'h1F, 8'h00, 5'h00);
    chk_bit(rdat[1], 1'h1);
  endtask

  task automatic t_status;
    wr(`OFF_CORE_A, 32'hA000_0001);
    cmd(5'h11, 3'h0, 5'h00, 8'h00, 5'h00);
    chk_bit(rdat[1], 1'h0);
    rd(`OFF_FP_STATUS_CONTROL_REG);
    chk_word(rdat, 32'hA000_0001);
    cmd(5'h10, 3'h0, 5'h00, 8'h00, 5'h00);
    rd(`OFF_RES_A);
    chk_word(rdat, 32'hA000_0001);
    cmd(5'h10, 3'h4, 5'h00, 8'h00, 5'h00);
    chk_word({28'h0, core_nzcv}, 32'h0000_000A);
  endtask

  // width qualifier: the double bit always matches the listed registers
  task automatic t_stack;
    cmd(5'h12, 3'h0, 5'h08, 8'h02, 5'h00);
    rd(`OFF_SP);
    chk_word(rdat, 32'h0000_00F8);
    sset(5'h08, 32'h0000_0000);
    sset(5'h09, 32'h0000_0000);
    cmd(5'h13, 3'h0, 5'h08, 8'h02, 5'h00);
    rd(`OFF_SP);
    chk_word(rdat, 32'h0000_0100);
    sget(5'h09);
    chk_word(rdat, 32'h0BEE_F002);
    cmd(5'h12, 3'h1, 5'h01, 8'h01, 5'h00);
    rd(`OFF_SP);
    chk_word(rdat, 32'h0000_00F8);
    sset(5'h03, 32'h0000_0000);
    cmd(5'h13, 3'h1, 5'h01, 8'h01, 5'h00);
    sget(5'h03);
    chk_word(rdat, 32'h4040_0000);
    cmd(5'h12, 3'h0, 5'h00, 8'h10, 5'h00);
    rd(`OFF_SP);
    chk_word(rdat, 32'h0000_00C0);
    cmd(5'h13, 3'h0, 5'h00, 8'h10, 5'h00);
    for (int c = 0; c < 18; c += 17) begin
      cmd(5'h12, 3'h0, 5'h00, 8'(c), 5'h00);
      chk_bit(rdat[1], 1'h1);
    end
    rd(`OFF_SP);
    chk_word(rdat, 32'h0000_0100);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      $display("MISMATCH t=%0t timeout", $time);
      finish_test();
    end
  end

  initial begin
    clk = 1'h0;
    rstn = 1'h0;
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    t_bus();
    t_arith();
    t_moves();
    t_xfer();
    t_status();
    t_stack();
    finish_test();
  end
endmodule // tb
